// ===== design/rpa_pkg.sv
/*
 * rpa_pkg: register map, field layout, reset values and frame
 * limits of the receive frame accept block.
 * assumes: imported by rpa_top and rx_packet_accept_config_test; one clock domain.
 */
package rpa_pkg;
    // ========================================================
    // register map (byte addresses)
    localparam logic [7:0]  RPA_CFG_OFS     = 8'h00;
    localparam logic [7:0]  RPA_CNT_OFS     = 8'h04;
    // ========================================================
    // receive_configuration fields
    localparam int          RPA_AEF_BIT     = 31;
    localparam int          RPA_ASF_BIT     = 30;
    localparam int          RPA_ADT_BIT     = 28;
    localparam int          RPA_AOF_BIT     = 27;
    localparam int          RPA_BURST_LSB   = 20;
    localparam int          RPA_RX_DRAIN_THRESHOLD_LSB    = 1;
    localparam logic [2:0]  RPA_BURST_RST   = 3'h0;
    localparam logic [4:0]  RPA_RX_DRAIN_THRESHOLD_RST    = 5'h01;
    localparam logic [7:0]  RPA_BURST_W_RST = 8'h80;
    // ========================================================
    // frame lengths in bytes: 64, 1514, 1518, 2046
    localparam logic [11:0] RPA_RUNT_LEN    = 12'h040;
    localparam logic [11:0] RPA_TRUNC_STD   = 12'h5EA;
    localparam logic [11:0] RPA_STD_MAX     = 12'h5EE;
    localparam logic [11:0] RPA_LONG_MAX    = 12'h7FE;
    localparam int          RPA_FIFO_DEPTH  = 8;
    // ========================================================
    // frame status word bits
    localparam int          RPA_ST_OK       = 0;
    localparam int          RPA_ST_CRC      = 1;
    localparam int          RPA_ST_ALIGN    = 2;
    localparam int          RPA_ST_COLL     = 3;
    localparam int          RPA_ST_RUNT     = 4;
    localparam int          RPA_ST_LONG     = 5;
    localparam int          RPA_ST_REJ      = 6;
    localparam int          RPA_ST_TXO      = 7;

    // code 0 is the largest burst, others are powers of two
    function automatic logic [7:0] rpa_burst_words(input logic [2:0] c);
        return (c == 3'h0) ? 8'h80 : 8'(8'h01 << (c - 3'h1));
    endfunction
endpackage

// ===== design/rpa_top.sv
/*
 * rpa_top: receive frame accept filter with its configuration
 * register, an AXI4-Lite slave and a small byte FIFO (rpa_fifo).
 * assumes: receive byte stream and DMA side on clk_in; status word
 * is copied into the last descriptor of the frame by the DMA engine.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
// Operation
// [RULE_01] accept-errored set: frames with crc, alignment, collision errors pass
// [RULE_02] accept-errored clear: such frames are rejected where still possible
// [RULE_03] errors of any delivered frame appear in its final status word
// [RULE_04] accept-short set: error-free frames under 64 bytes are accepted
// [RULE_05] accept-short clear: frames under 64 bytes rejected where possible
// [RULE_06] accept-during-transmit set: overlap data valid, collisions ignored
// [RULE_07] accept-during-transmit resets to 0 and then rejects overlap data
// [RULE_08] software sets accept-during-transmit before loopback or full duplex
// [RULE_09] oversize accepted: 1519 to 2046 byte frames are normal frames
// [RULE_10] oversize accepted: longer frames cut at 2046 and tagged long
// [RULE_11] oversize clear: frames over 1518 cut at 1514 and rejected
// [RULE_12] bits 25 to 23 ignore writes and read zero
// [RULE_13] bits 22 to 20 limit each receive DMA burst
// [RULE_14] burst code 0 means 128 words, codes 1 to 7 mean 1 to 64
// [RULE_15] drain starts at threshold times 8 bytes or whole frame; zero illegal; code also starts drain when the fifo is full
`timescale 1ns/1ps
module rpa_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } rpa_fifo_t;
    rpa_fifo_t st;
    rpa_fifo_t next_st;

    assign out_valid_out = (st.wr != st.rd);
    assign in_ready_out  = !((st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]));
    assign out_data_out  = st.mem[st.rd[AW-1:0]];

    always_comb begin
        next_st = st;
        if (in_valid_in && in_ready_out) begin
            next_st.mem[st.wr[AW-1:0]] = in_data_in;
            next_st.wr                 = st.wr + (AW+1)'(1);
        end
        if (out_valid_out && out_ready_in) begin
            next_st.rd = st.rd + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

module rpa_top
    import rpa_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [31:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [31:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic        rx_last_in,
    input  wire logic        rx_crc_err_in,
    input  wire logic        rx_align_err_in,
    input  wire logic        rx_coll_in,
    input  wire logic        tx_active_in,
    output logic             rx_ready_out,
    output logic             out_valid_out,
    output logic [7:0]       out_data_out,
    output logic             out_last_out,
    input  wire logic        out_ready_in,
    output logic             sts_valid_out,
    output logic [7:0]       sts_out,
    output logic [7:0]       rx_burst_words_out
);
    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        accept_errored_frames;
        logic        accept_short_frames;
        logic        accept_during_transmit;
        logic        accept_oversize_frames;
        logic [2:0]  rx_burst_limit;
        logic [4:0]  rx_drain_threshold;
        logic [7:0]  burst_words;
        logic        in_frame;
        logic        drop;
        logic        txo;
        logic        coll;
        logic [11:0] cnt;
        logic        sts_valid;
        logic [7:0]  sts;
        logic [15:0] acc_cnt;
        logic [15:0] rej_cnt;
        logic [3:0]  ends;
        logic        started;
    } rpa_state_t;
    rpa_state_t st;
    rpa_state_t next_st;

    function automatic logic [31:0] cfg_word(input rpa_state_t s);
        logic [31:0] w;
        w                                = '0;
        w[RPA_AEF_BIT]                   = s.accept_errored_frames;
        w[RPA_ASF_BIT]                   = s.accept_short_frames;
        w[RPA_ADT_BIT]                   = s.accept_during_transmit;
        w[RPA_AOF_BIT]                   = s.accept_oversize_frames;
        w[RPA_BURST_LSB +: 3]            = s.rx_burst_limit;
        w[RPA_RX_DRAIN_THRESHOLD_LSB +: 5]             = s.rx_drain_threshold;
        return w;
    endfunction

    logic        f_in_valid;
    logic        f_in_ready;
    logic        f_out_valid;
    logic [8:0]  f_out_data;
    logic        keep;
    logic        drop_now;
    logic        last_mark;
    logic        go;
    logic [11:0] lim;

    // ========================================================
    // byte buffer between filter and bus master
    rpa_fifo #(.WIDTH(9), .DEPTH(RPA_FIFO_DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (f_in_valid),
        .in_data_in    ({last_mark, rx_data_in}),
        .in_ready_out  (f_in_ready),
        .out_valid_out (f_out_valid),
        .out_data_out  (f_out_data),
        .out_ready_in  (out_ready_in && go)
    );

    // ========================================================
    // frame filter combinational terms
    assign lim        = st.accept_oversize_frames ? RPA_LONG_MAX : RPA_TRUNC_STD; // [RULE_10] [RULE_11]
    assign drop_now   = st.in_frame ? st.drop : (tx_active_in && !st.accept_during_transmit); // [RULE_07]
    assign keep       = !drop_now && (st.cnt < lim);
    assign last_mark  = rx_last_in || (st.cnt == lim - 12'h001);
    assign f_in_valid = rx_valid_in && keep;
    // truncated or dropped bytes are swallowed, so the source never stalls on them
    assign rx_ready_out = !keep || f_in_ready;
    // full fifo also starts drain: 8 bytes hold less than most thresholds
    assign go = st.started || (st.ends != 4'h0) || !f_in_ready
             || ({st.cnt} >= {4'h0, st.rx_drain_threshold, 3'h0}); // [RULE_15]

    assign out_valid_out      = f_out_valid && go;
    assign out_data_out       = f_out_data[7:0];
    assign out_last_out       = f_out_data[8];
    assign s_axi_awready_out  = !st.aw_got && !st.bvalid;
    assign s_axi_wready_out   = !st.w_got && !st.bvalid;
    assign s_axi_bvalid_out   = st.bvalid;
    assign s_axi_bresp_out    = st.bresp;
    assign s_axi_arready_out  = !st.rvalid;
    assign s_axi_rvalid_out   = st.rvalid;
    assign s_axi_rdata_out    = st.rdata;
    assign s_axi_rresp_out    = st.rresp;
    assign sts_valid_out      = st.sts_valid;
    assign sts_out            = st.sts;
    assign rx_burst_words_out = st.burst_words;

    always_comb begin
        logic [31:0] w;
        logic [11:0] len;
        logic        txo;
        logic        coll;
        logic        err;
        logic        runt;
        logic        lng;
        logic        rej;
        logic        wr_last;
        logic        rd_last;
        w       = '0;
        len     = '0;
        txo     = 1'b0;
        coll    = 1'b0;
        err     = 1'b0;
        runt    = 1'b0;
        lng     = 1'b0;
        rej     = 1'b0;
        wr_last = 1'b0;
        rd_last = 1'b0;
        next_st = st;
        next_st.sts_valid = 1'b0;
        // ====================================================
        // register bus, address and data in either order
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_st.aw_got = 1'b1;
            next_st.waddr  = s_axi_awaddr_in[7:0];
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata_in;
            next_st.wstrb = s_axi_wstrb_in;
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = 2'h0;
            if (st.waddr == RPA_CFG_OFS) begin
                w = cfg_word(st);
                for (int b = 0; b < 4; b++) begin
                    if (st.wstrb[b]) begin
                        w[8*b +: 8] = st.wdata[8*b +: 8];
                    end
                end
                // unused bits are simply not stored
                next_st.accept_errored_frames  = w[RPA_AEF_BIT];
                next_st.accept_short_frames    = w[RPA_ASF_BIT];
                next_st.accept_during_transmit = w[RPA_ADT_BIT];
                next_st.accept_oversize_frames = w[RPA_AOF_BIT];
                next_st.rx_burst_limit         = w[RPA_BURST_LSB +: 3]; // [RULE_13]
                next_st.rx_drain_threshold     = w[RPA_RX_DRAIN_THRESHOLD_LSB +: 5];
            end else if (st.waddr != RPA_CNT_OFS) begin
                next_st.bresp = 2'h2;
            end
        end
        if (st.bvalid && s_axi_bready_in) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = 2'h0;
            if (s_axi_araddr_in[7:0] == RPA_CFG_OFS) begin
                next_st.rdata = cfg_word(st); // [RULE_12]
            end else if (s_axi_araddr_in[7:0] == RPA_CNT_OFS) begin
                next_st.rdata = {st.rej_cnt, st.acc_cnt};
            end else begin
                next_st.rdata = '0;
                next_st.rresp = 2'h2;
            end
        end else if (st.rvalid && s_axi_rready_in) begin
            next_st.rvalid = 1'b0;
        end
        next_st.burst_words = rpa_burst_words(st.rx_burst_limit); // [RULE_14]
        // ====================================================
        // receive side: count, truncate, classify at frame end
        if (rx_valid_in && rx_ready_out) begin
            len  = (st.cnt == 12'hFFF) ? st.cnt : st.cnt + 12'h001;
            txo  = (st.in_frame && st.txo) || (tx_active_in && !st.accept_during_transmit); // [RULE_07]
            coll = (st.in_frame && st.coll) || (rx_coll_in && !st.accept_during_transmit); // [RULE_06]
            next_st.cnt      = len;
            next_st.in_frame = 1'b1;
            next_st.drop     = drop_now;
            next_st.txo      = txo;
            next_st.coll     = coll;
            if (rx_last_in) begin
                err  = rx_crc_err_in || rx_align_err_in || coll;
                runt = len < RPA_RUNT_LEN;
                lng  = st.accept_oversize_frames ? (len > RPA_LONG_MAX) : (len > RPA_STD_MAX); // [RULE_09]
                rej  = (err && !st.accept_errored_frames) // [RULE_01] [RULE_02]
                    || (runt && !st.accept_short_frames) // [RULE_04] [RULE_05]
                    || (lng && !st.accept_oversize_frames) // [RULE_10] [RULE_11]
                    || txo;
                next_st.sts_valid              = 1'b1;
                next_st.sts                    = '0;
                next_st.sts[RPA_ST_OK]         = !rej && !err;
                next_st.sts[RPA_ST_CRC]        = rx_crc_err_in; // [RULE_03]
                next_st.sts[RPA_ST_ALIGN]      = rx_align_err_in;
                next_st.sts[RPA_ST_COLL]       = coll;
                next_st.sts[RPA_ST_RUNT]       = runt;
                next_st.sts[RPA_ST_LONG]       = lng;
                next_st.sts[RPA_ST_REJ]        = rej;
                next_st.sts[RPA_ST_TXO]        = txo;
                next_st.in_frame = 1'b0;
                next_st.drop     = 1'b0;
                next_st.txo      = 1'b0;
                next_st.coll     = 1'b0;
                next_st.cnt      = '0;
                if (rej) begin
                    next_st.rej_cnt = st.rej_cnt + 16'h0001;
                end else begin
                    next_st.acc_cnt = st.acc_cnt + 16'h0001;
                end
            end
        end
        // ====================================================
        // drain bookkeeping: whole frames held and frame in flight
        wr_last = f_in_valid && f_in_ready && last_mark;
        rd_last = out_valid_out && out_ready_in && out_last_out;
        next_st.ends = st.ends + {3'h0, wr_last} - {3'h0, rd_last};
        if (out_valid_out && out_ready_in) begin
            next_st.started = !out_last_out;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st                    <= '0;
            st.rx_burst_limit     <= RPA_BURST_RST;
            st.rx_drain_threshold <= RPA_RX_DRAIN_THRESHOLD_RST;
            st.burst_words        <= RPA_BURST_W_RST;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // checks
    chk_errored_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_02]
        st.sts_valid && st.sts[RPA_ST_CRC] && !$past(st.accept_errored_frames)
        |-> st.sts[RPA_ST_REJ])
        else $error("errored frame not rejected");
    chk_errored_pass: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_01]
        st.sts_valid && $past(st.accept_errored_frames) && !st.sts[RPA_ST_RUNT]
        && !st.sts[RPA_ST_LONG] && !st.sts[RPA_ST_TXO] |-> !st.sts[RPA_ST_REJ])
        else $error("errored frame rejected while accepted");
    chk_short_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_05]
        st.sts_valid && st.sts[RPA_ST_RUNT] && !$past(st.accept_short_frames)
        |-> st.sts[RPA_ST_REJ])
        else $error("short frame not rejected");
    chk_short_pass: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_04]
        st.sts_valid && st.sts[RPA_ST_RUNT] && $past(st.accept_short_frames)
        && !st.sts[RPA_ST_CRC] && !st.sts[RPA_ST_ALIGN] && !st.sts[RPA_ST_COLL]
        && !st.sts[RPA_ST_TXO] |-> !st.sts[RPA_ST_REJ])
        else $error("accepted short frame rejected");
    chk_trunc_std: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_11]
        st.sts_valid && st.sts[RPA_ST_LONG] && !$past(st.accept_oversize_frames)
        |-> st.sts[RPA_ST_REJ])
        else $error("oversize frame not rejected");
    chk_trunc_long: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_10]
        f_in_valid && f_in_ready
        |-> st.cnt < (st.accept_oversize_frames ? RPA_LONG_MAX : RPA_TRUNC_STD))
        else $error("byte stored past cut point");
    chk_unused_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_12]
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:0] == RPA_CFG_OFS
        |=> st.rdata[25:23] == 3'h0)
        else $error("unused bits read nonzero");
    chk_burst_code: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_14]
        st.rx_burst_limit == 3'h0 ##1 st.rx_burst_limit == 3'h0 |-> st.burst_words == 8'h80)
        else $error("burst code 0 not 128 words");
    chk_overlap_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_07]
        st.sts_valid && st.sts[RPA_ST_TXO] |-> st.sts[RPA_ST_REJ])
        else $error("overlap frame not rejected");
    chk_drain_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_15]
        out_valid_out && !st.started && st.ends == 4'h0 && f_in_ready
        |-> st.cnt >= {4'h0, st.rx_drain_threshold, 3'h0})
        else $error("drain started below threshold");
endmodule

// ===== test/rpa_phy_model.sv
/* rpa_phy_model: receive byte source standing in for the PHY path.
   assumes: one clock; send_frame is called only after reset ends. */
`timescale 1ns/1ps
module rpa_phy_model (
    input  wire logic       clk_in,
    input  wire logic       rx_ready_in,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_last_out,
    output logic            rx_crc_err_out,
    output logic            rx_align_err_out,
    output logic            rx_coll_out,
    output logic            tx_active_out
);
    initial begin
        {rx_valid_out, rx_last_out, rx_crc_err_out} = '0;
        {rx_align_err_out, rx_coll_out, tx_active_out} = '0;
        rx_data_out = 8'h5A;
    end
    // ==========================================
    // one frame, each byte held until it is taken or 1000 cycles pass
    task automatic send_frame(input int len, input bit crc, al, co, tx, output bit ok);
        int i;
        int w;
        ok = 1'b1;
        @(posedge clk_in);
        tx_active_out <= tx;
        for (i = 0; i < len && ok; i++) begin
            rx_valid_out <= 1'b1;
            rx_data_out <= i[7:0];
            rx_last_out <= (i == len - 1);
            rx_crc_err_out <= crc && (i == len - 1);
            rx_align_err_out <= al && (i == len - 1);
            rx_coll_out <= co;
            w = 0;
            do begin
                @(posedge clk_in);
                w++;
            end while (!rx_ready_in && w < 1000);
            ok = rx_ready_in;
        end
        // released data line must not look like a held byte
        rx_valid_out <= 1'b0;
        rx_data_out <= ~rx_data_out;
        {rx_last_out, rx_crc_err_out, rx_align_err_out} <= '0;
        rx_coll_out <= 1'b0;
        tx_active_out <= 1'b0;
    endtask
endmodule

// ===== test/rx_packet_accept_config_test.sv
/* rx_packet_accept_config_test: register, burst and frame filter scenarios.
   assumes: rpa_phy_model drives the receive side; sink stalls 3 of 4 cycles. */
`timescale 1ns/1ps
module rx_packet_accept_config_test;
    import rpa_pkg::*;
    logic        clk_in = 0, rst_n_in = 0, out_ready = 0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, out_valid, out_last;
    logic        sts_valid, rx_ready, rx_valid, rx_last, crc, al, co, tx;
    logic [1:0]  bresp, rresp;
    logic [7:0]  out_data, sts, burst, rx_data, sts_seen = '0;
    logic [3:0]  tick = '0;
    logic [3:0]  strb = 4'hF;
    int          failures = 0, tests_run = 0, n_sts = 0, n_last = 0, cnt = 0, last_len = 0;
    always #2 clk_in = ~clk_in;
    rpa_top i_rpa_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
        .rx_last_in(rx_last), .rx_crc_err_in(crc), .rx_align_err_in(al), .rx_coll_in(co),
        .tx_active_in(tx), .rx_ready_out(rx_ready), .out_valid_out(out_valid),
        .out_data_out(out_data), .out_last_out(out_last), .out_ready_in(out_ready),
        .sts_valid_out(sts_valid), .sts_out(sts), .rx_burst_words_out(burst));
    rpa_phy_model i_rpa_phy_model (.clk_in(clk_in), .rx_ready_in(rx_ready),
        .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_last_out(rx_last),
        .rx_crc_err_out(crc), .rx_align_err_out(al), .rx_coll_out(co), .tx_active_out(tx));
    // ==========================================
    // stalling sink and status capture
    always @(posedge clk_in) begin
        tick <= tick + 4'h1;
        out_ready <= (tick[1:0] == 2'h0);
        if (sts_valid) begin
            sts_seen <= sts;
            n_sts <= n_sts + 1;
        end
        if (out_valid && out_ready) begin
            check(32'(out_data), 32'(cnt[7:0]), "byte order");
            cnt <= out_last ? 0 : cnt + 1;
            if (out_last) begin
                last_len <= cnt + 1;
                n_last <= n_last + 1;
            end
        end
    end
    // ==========================================
    task automatic results();
        $display("comparisons %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s %h vs %h", $time, m, seen, exp);
        end
    endtask
    task automatic lim(input int n, m);
        if (n >= m) begin
            failures++;
            results();
        end
    endtask
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
        int n;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        lim(n, 100);
        bready <= 1'b0;
        check(32'(bresp), 32'(er), "write response");
    endtask
    task automatic rd(input logic [31:0] a, e, input logic [1:0] er, input string m);
        int n;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        lim(n, 100);
        rready <= 1'b0;
        check(rdata, e, m);
        check(32'(rresp), 32'(er), m);
    endtask
    // frame, then wait for status and, if stored, for the drained last byte
    task automatic frame(input int len, input bit c, a, o, t, dr, input logic [7:0] mk, ex);
        int ns, nl, n;
        bit ok;
        ns = n_sts;
        nl = n_last;
        i_rpa_phy_model.send_frame(len, c, a, o, t, ok);
        for (n = 0; n < 20000 && (n_sts == ns || (dr && n_last == nl)); n++) @(posedge clk_in);
        lim(n, 20000);
        check(32'(ok), 32'h1, "byte never taken");
        check(32'(sts_seen & mk), 32'(ex), "frame status");
    endtask
    // ==========================================
    task automatic t_regs();
        rd(32'h0000_0000, 32'h0000_0002, 2'h0, "reset value");
        wr(32'h0000_0000, 32'hFFFF_FFFF, 2'h0);
        rd(32'h0000_0000, 32'hD870_003E, 2'h0, "unused bits");
        strb <= 4'h8;
        wr(32'h0000_0000, 32'h0000_0000, 2'h0);
        strb <= 4'hF;
        rd(32'h0000_0000, 32'h0070_003E, 2'h0, "byte lanes");
        wr(32'h0000_0010, 32'h1234_5678, 2'h2);
        rd(32'h0000_0010, 32'h0000_0000, 2'h2, "unmapped read");
    endtask
    task automatic t_burst();
        logic [7:0] tbl [8] = '{8'h80, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
        for (int c = 0; c < 8; c++) begin
            wr(32'h0000_0000, (32'(c) << 20) | 32'h0000_0002, 2'h0);
            rd(32'h0000_0000, (32'(c) << 20) | 32'h0000_0002, 2'h0, "burst code");
            check(32'(burst), 32'(tbl[c]), "burst words");
        end
    endtask
    task automatic t_errored();
        wr(32'h0000_0000, 32'h0000_0002, 2'h0);
        frame(64, 1, 0, 0, 0, 1, 8'h7E, 8'h42);
        frame(64, 0, 1, 0, 0, 1, 8'h44, 8'h44);
        wr(32'h0000_0000, 32'h8000_0002, 2'h0);
        frame(64, 1, 0, 0, 0, 1, 8'h7E, 8'h02);
        frame(64, 0, 0, 1, 0, 1, 8'h7E, 8'h08);
    endtask
    task automatic t_short();
        wr(32'h0000_0000, 32'h0000_0002, 2'h0);
        frame(10, 0, 0, 0, 0, 1, 8'h40, 8'h40);
        wr(32'h0000_0000, 32'h4000_0002, 2'h0);
        frame(63, 0, 0, 0, 0, 1, 8'h4F, 8'h01);
    endtask
    task automatic t_overlap();
        wr(32'h0000_0000, 32'h0000_0002, 2'h0);
        frame(64, 0, 0, 0, 1, 0, 8'h40, 8'h40);
        wr(32'h0000_0000, 32'h1000_0002, 2'h0);
        frame(64, 0, 0, 1, 1, 1, 8'h49, 8'h01);
    endtask
    task automatic t_long();
        wr(32'h0000_0000, 32'h0000_0002, 2'h0);
        frame(1518, 0, 0, 0, 0, 1, 8'h60, 8'h00);
        frame(1600, 0, 0, 0, 0, 1, 8'h40, 8'h40);
        check(32'(last_len), 32'd1514, "cut length");
        wr(32'h0000_0000, 32'h0800_0002, 2'h0);
        frame(2046, 0, 0, 0, 0, 1, 8'h60, 8'h00);
        check(32'(last_len), 32'd2046, "long length");
        frame(2100, 0, 0, 0, 0, 1, 8'h60, 8'h20);
        check(32'(last_len), 32'd2046, "cut length");
        rd(32'h0000_0004, 32'h0005_0007, 2'h0, "frame counts");
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_burst();
        t_errored();
        t_short();
        t_overlap();
        t_long();
        results();
    end
endmodule
